// ---- shared/wdog_pkg.sv ----
// Constants, register map and carrier types for the watchdog and reset
// source block. Assumes a 200 MHz mclk and an APB master with 32-bit data.
package wdog_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [15:0] CLEAR_LOC_OFS = 16'h3FF0;
  localparam logic [15:0] CTRL_OFS = 16'h0000;
  localparam logic [15:0] STATUS_OFS = 16'h0004;
  localparam logic [15:0] USER_BYTE_OFS = 16'h0008;

  // Field positions.
  localparam int CLEAR_BIT_POS = 0;
  localparam int CTRL_WIN_POS = 0;
  localparam int ST_PHASE_POS = 0;
  localparam int ST_RC_POS = 1;
  localparam int ST_WIN_POS = 2;
  localparam int ST_CAUSE_POS = 3;

  // Reset values.
  localparam logic [7:0] USER_BYTE_RST = 8'hFF;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int WDOG_BITS = 16;
  localparam int STARTUP_CYCLES = 4064;
  localparam int STARTUP_BITS = 12;
  localparam int MON_MIN_HZ = 10000;
  localparam int MON_SAFE_HZ = 400000;
  // Longest gap between ticks before failure, 1/10 KHz in mclk cycles.
  localparam int MON_TIMEOUT_CYC = (CLK_MHZ * 1000000) / MON_MIN_HZ;
  localparam int MON_BITS = 15;

  // ----------------------------------------------------------------------
  // Illegal fetch regions
  // ----------------------------------------------------------------------
  localparam logic [15:0] IO_LO = 16'h0000;
  localparam logic [15:0] IO_HI = 16'h003F;
  localparam logic [15:0] UNIMP1_LO = 16'h0100;
  localparam logic [15:0] UNIMP1_HI = 16'h017F;
  localparam logic [15:0] UNIMP2_LO = 16'h0200;
  localparam logic [15:0] UNIMP2_HI = 16'h1FFF;
  localparam logic [15:0] MON_LO = 16'h3F00;
  localparam logic [15:0] MON_HI = 16'h3FEF;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic watchdog_option_enable;
    logic stop_disable;
    logic temp_reset_enable;
    logic volt_reset_enable;
    logic clock_monitor_enable;
  } option_register_s;

  typedef struct packed {
    logic over_temp_high;
    logic over_temp_low;
    logic over_volt_high;
    logic over_volt_low;
    logic under_volt_trip;
    logic under_volt_ok;
    logic power_on_seq;
  } detector_s;

  typedef struct packed {
    logic watchdog;
    logic illegal_fetch;
    logic stop_illegal;
    logic over_temperature_reset;
    logic over_voltage_reset;
    logic under_voltage_reset;
    logic clock_monitor_reset;
  } reset_cause_s;

  typedef enum logic [2:0] {
    RUN_ST = 3'b001,
    STOP_ST = 3'b010,
    WAKE_ST = 3'b100
  } pmode_e;

endpackage

// ---- rtl/wdog_reset_sources.sv ----
// Watchdog with windowed clear, internal reset sources and clock monitor.
// Assumes an APB master, synchronous status inputs and a core tick stream.
`timescale 1ns/1ps
module wdog_reset_sources (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core events
  input wire logic wdog_tick,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic stop_exec,
  input wire logic wait_state,
  input wire logic stop_wake_irq,
  input wire logic proc_clk_tick,
  // Options and detectors
  input wire wdog_pkg::option_register_s option_register,
  input wire wdog_pkg::detector_s detectors,
  // Reset results
  output logic system_reset,
  output logic reset_pin_pulldown,
  output wdog_pkg::reset_cause_s reset_cause,
  output logic rc_oscillator_in_use
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  logic access;
  logic wr;
  logic rd;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  // ----------------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------------
  wdog_pkg::pmode_e pmode_q;
  logic [wdog_pkg::STARTUP_BITS-1:0] startup_q;
  logic stop_enter;
  assign stop_enter = stop_exec && !option_register.stop_disable &&
                      (pmode_q == wdog_pkg::RUN_ST);

  // The recovery delay only follows an interrupt wake; a reset wake is
  // covered by the hold below after system_reset.
  always_ff @(posedge mclk) begin
    if (rst || system_reset) begin
      pmode_q <= wdog_pkg::RUN_ST;
      startup_q <= '0;
    end else begin
      unique case (pmode_q)
        wdog_pkg::RUN_ST: begin
          if (stop_enter) begin
            pmode_q <= wdog_pkg::STOP_ST;
          end
        end
        wdog_pkg::STOP_ST: begin
          if (stop_wake_irq) begin
            pmode_q <= wdog_pkg::WAKE_ST;
            startup_q <= '0;
          end
        end
        wdog_pkg::WAKE_ST: begin
          if (startup_q == wdog_pkg::STARTUP_BITS'(
              wdog_pkg::STARTUP_CYCLES - 1)) begin
            pmode_q <= wdog_pkg::RUN_ST;
          end else begin
            startup_q <= startup_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Start-up hold after any reset that leaves stop, and after power-up.
  logic [wdog_pkg::STARTUP_BITS-1:0] hold_q;
  logic hold_active_q;
  always_ff @(posedge mclk) begin
    if (rst || system_reset) begin
      hold_q <= '0;
      hold_active_q <= 1'b1;
    end else if (hold_active_q) begin
      if (hold_q == wdog_pkg::STARTUP_BITS'(
          wdog_pkg::STARTUP_CYCLES - 1)) begin
        hold_active_q <= 1'b0;
      end else begin
        hold_q <= hold_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  logic [7:0] user_byte_q;
  logic win_enable_q;
  logic win_written_q;
  logic clear_wr;
  logic mapped;
  assign clear_wr = wr && hit(paddr, wdog_pkg::CLEAR_LOC_OFS) &&
                    !pwdata[wdog_pkg::CLEAR_BIT_POS];
  assign mapped = hit(paddr, wdog_pkg::CLEAR_LOC_OFS) ||
                  hit(paddr, wdog_pkg::CTRL_OFS) ||
                  hit(paddr, wdog_pkg::STATUS_OFS) ||
                  hit(paddr, wdog_pkg::USER_BYTE_OFS);

  // The user byte stands in for the programmed vector byte; software
  // loads it through its own offset, the clear location never stores.
  always_ff @(posedge mclk) begin
    if (rst) begin
      user_byte_q <= wdog_pkg::USER_BYTE_RST;
    end else if (wr && hit(paddr, wdog_pkg::USER_BYTE_OFS)) begin
      user_byte_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || system_reset) begin
      win_enable_q <= 1'b0;
      win_written_q <= 1'b0;
    end else if (wr && hit(paddr, wdog_pkg::CTRL_OFS) &&
                 !win_written_q) begin
      win_enable_q <= pwdata[wdog_pkg::CTRL_WIN_POS];
      win_written_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------------
  logic [wdog_pkg::WDOG_BITS-1:0] wdog_q;
  logic phase;
  logic wdog_expire;
  logic early_clear;
  assign phase = wdog_q[wdog_pkg::WDOG_BITS-1];
  assign early_clear = clear_wr && win_enable_q && !phase;
  assign wdog_expire = option_register.watchdog_option_enable &&
                       wdog_tick && (&wdog_q) &&
                       (pmode_q == wdog_pkg::RUN_ST);

  always_ff @(posedge mclk) begin
    if (rst || hold_active_q || stop_enter) begin
      wdog_q <= '0;
    end else if (clear_wr) begin
      wdog_q <= '0;
    end else if (wdog_tick && pmode_q == wdog_pkg::RUN_ST) begin
      // Wait keeps ticking; the wake delay leaves the count alone.
      wdog_q <= wdog_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Environmental requests with hysteresis
  // ----------------------------------------------------------------------
  logic temp_q;
  logic volt_q;
  logic uv_q;
  always_ff @(posedge mclk) begin
    if (rst || !option_register.temp_reset_enable) begin
      temp_q <= 1'b0;
    end else if (detectors.over_temp_high) begin
      temp_q <= 1'b1;
    end else if (detectors.over_temp_low) begin
      temp_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !option_register.volt_reset_enable) begin
      volt_q <= 1'b0;
    end else if (detectors.over_volt_high) begin
      volt_q <= 1'b1;
    end else if (detectors.over_volt_low) begin
      volt_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      uv_q <= 1'b0;
    end else if (detectors.under_volt_trip) begin
      uv_q <= 1'b1;
    end else if (detectors.under_volt_ok || detectors.power_on_seq) begin
      uv_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Clock monitor
  // ----------------------------------------------------------------------
  logic [wdog_pkg::MON_BITS-1:0] mon_q;
  logic mon_fail;
  logic mon_run;
  // Frozen in stop and through the wake delay.
  assign mon_run = option_register.clock_monitor_enable &&
                   (pmode_q == wdog_pkg::RUN_ST);
  assign mon_fail = mon_run && !proc_clk_tick &&
                    (mon_q == wdog_pkg::MON_BITS'(
                     wdog_pkg::MON_TIMEOUT_CYC - 1));

  always_ff @(posedge mclk) begin
    if (rst || proc_clk_tick || mon_fail) begin
      mon_q <= '0;
    end else if (mon_run) begin
      mon_q <= mon_q + 1'b1;
    end
  end

  // Oscillator choice survives stop and any later reset except power-up.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rc_oscillator_in_use <= 1'b0;
    end else if (mon_fail) begin
      rc_oscillator_in_use <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Reset combination
  // ----------------------------------------------------------------------
  wdog_pkg::reset_cause_s cause_d;
  logic illegal;
  always_comb begin
    illegal = fetch_valid && pmode_q == wdog_pkg::RUN_ST &&
              (in_range(fetch_addr, wdog_pkg::IO_LO, wdog_pkg::IO_HI) ||
               in_range(fetch_addr, wdog_pkg::UNIMP1_LO,
                        wdog_pkg::UNIMP1_HI) ||
               in_range(fetch_addr, wdog_pkg::UNIMP2_LO,
                        wdog_pkg::UNIMP2_HI) ||
               in_range(fetch_addr, wdog_pkg::MON_LO,
                        wdog_pkg::MON_HI));
    cause_d.watchdog = wdog_expire || early_clear;
    cause_d.illegal_fetch = illegal;
    cause_d.stop_illegal = stop_exec && option_register.stop_disable &&
                           !wait_state;
    cause_d.over_temperature_reset = temp_q;
    cause_d.over_voltage_reset = volt_q;
    cause_d.under_voltage_reset = uv_q;
    cause_d.clock_monitor_reset = mon_fail;
  end

  // Temperature and voltage sources assert reset regardless of wait or stop, which ends
  // stop and the wake delay through the system_reset term above; wait is an input and stays as driven.
  always_ff @(posedge mclk) begin
    if (rst) begin
      system_reset <= 1'b0;
      reset_pin_pulldown <= 1'b0;
    end else begin
      system_reset <= |cause_d;
      reset_pin_pulldown <= |cause_d;
    end
  end

  // Last cause stays visible until the next source fires.
  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_cause <= '0;
    end else if (|cause_d) begin
      reset_cause <= cause_d;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer: zero wait states
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, wdog_pkg::CLEAR_LOC_OFS) ||
            hit(paddr, wdog_pkg::USER_BYTE_OFS)) begin
          prdata[7:0] <= user_byte_q;
        end else if (hit(paddr, wdog_pkg::CTRL_OFS)) begin
          prdata[wdog_pkg::CTRL_WIN_POS] <= win_enable_q;
        end else if (hit(paddr, wdog_pkg::STATUS_OFS)) begin
          // Bits are placed by position so the map is kept in one place.
          prdata[wdog_pkg::ST_PHASE_POS] <= phase;
          prdata[wdog_pkg::ST_RC_POS] <= rc_oscillator_in_use;
          prdata[wdog_pkg::ST_WIN_POS] <= win_enable_q;
          prdata[wdog_pkg::ST_CAUSE_POS] <= |reset_cause;
        end
      end
    end
  end

  logic unused;
  assign unused = rd;

endmodule

// ---- test/wdog_checker.sv ----
// Concurrent checks for the watchdog and reset source block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module wdog_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus and core events
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic stop_exec,
  input wire wdog_pkg::option_register_s option_register,
  input wire wdog_pkg::detector_s detectors,
  // Results
  input wire logic system_reset,
  input wire logic reset_pin_pulldown,
  input wire wdog_pkg::reset_cause_s reset_cause
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  function automatic logic bad(input logic [15:0] a);
    return a <= wdog_pkg::IO_HI ||
      (a >= wdog_pkg::UNIMP1_LO && a <= wdog_pkg::UNIMP1_HI) ||
      (a >= wdog_pkg::UNIMP2_LO && a <= wdog_pkg::UNIMP2_HI) ||
      (a >= wdog_pkg::MON_LO && a <= wdog_pkg::MON_HI);
  endfunction

  sequence s_hot;
    option_register.temp_reset_enable && detectors.over_temp_high;
  endsequence
  sequence s_setup;
    psel && !penable;
  endsequence

  a_pulldown_follows:
    assert property (reset_pin_pulldown == system_reset)
    else $error("Pull-down differs from system reset.");
  a_bad_fetch:
    assert property (fetch_valid && bad(fetch_addr) |-> ##[1:2] system_reset)
    else $error("Illegal fetch gave no reset.");
  a_stop_reset:
    assert property (stop_exec && option_register.stop_disable |->
      ##[1:2] system_reset) else $error("Disabled stop gave no reset.");
  a_temp_reset:
    assert property (s_hot |-> ##[1:2] system_reset)
    else $error("Over-temperature gave no reset.");
  a_temp_hold:
    assert property (s_hot ##1 (option_register.temp_reset_enable &&
      !detectors.over_temp_low) [*4] |-> system_reset)
    else $error("Over-temperature reset dropped early.");
  a_volt_reset:
    assert property (option_register.volt_reset_enable &&
      detectors.over_volt_high |-> ##[1:2] system_reset)
    else $error("Over-voltage gave no reset.");
  a_uv_reset:
    assert property (detectors.under_volt_trip |-> ##[1:2] system_reset)
    else $error("Under-voltage gave no reset.");
  a_cause_recorded:
    assert property ($rose(system_reset) |-> reset_cause != '0)
    else $error("Reset without a recorded cause.");
  a_read_user:
    assert property (s_setup ##0 (!pwrite &&
      paddr == wdog_pkg::CLEAR_LOC_OFS) |=> pready && !pslverr)
    else $error("Clear location read refused.");
endmodule

bind wdog_reset_sources wdog_checker u_chk (.mclk, .rst, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .fetch_valid, .fetch_addr,
  .stop_exec, .option_register, .detectors, .system_reset,
  .reset_pin_pulldown, .reset_cause);

// ---- test/watchdog_and_reset_sources_test.sv ----
// Self-checking bench for the watchdog and reset source block.
// Assumes the zero-wait APB slave and the 4064-cycle hold after reset.
`timescale 1ns/1ps
module watchdog_and_reset_sources_test;
  typedef struct packed {logic e; logic [31:0] m; logic [31:0] d;} exp_s;
  localparam exp_s WR = '0;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 16'h0000, fetch_addr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h52;
  logic pready, pslverr, system_reset, reset_pin_pulldown;
  logic wdog_tick = 0, fetch_valid = 0, stop_exec = 0, wait_state = 0;
  logic stop_wake_irq = 0, proc_clk_tick = 0, run_clk = 1;
  logic rc_oscillator_in_use;
  wdog_pkg::option_register_s option_register = 5'h1F;
  wdog_pkg::detector_s detectors = 7'h00;
  wdog_pkg::reset_cause_s reset_cause;
  logic [16:0] fz [6] = '{17'h1003F, 17'h00040, 17'h1017F, 17'h00180,
    17'h11FFF, 17'h13F00};
  int error_cnt = 0, tests_run = 0, n;
  exp_s q[$], got;

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) proc_clk_tick <= run_clk & ~proc_clk_tick;

  wdog_reset_sources DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .wdog_tick, .fetch_valid,
    .fetch_addr, .stop_exec, .wait_state, .stop_wake_irq, .proc_clk_tick,
    .option_register, .detectors, .system_reset, .reset_pin_pulldown,
    .reset_cause, .rc_oscillator_in_use);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One idle cycle before each setup keeps psel from being driven twice.
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
           input exp_s x);
    int i;
    @(posedge mclk);
    q.push_back(x);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) begin
        error_cnt++;
        $display("ERROR at %0t: answer with no request", $time);
      end else begin
        got = q.pop_front();
        check({pslverr, prdata & got.m}, {got.e, got.d & got.m});
      end
    end
  end

  task expect_rst(input int lim, input logic want, input int cb);
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < lim && !seen; i++) begin
      @(posedge mclk);
      seen = (system_reset === 1'b1);
    end
    check({32'h0, seen}, {32'h0, want});
    if (seen && cb >= 0) check({32'h0, reset_cause[cb]}, 33'h1);
    if (want && !seen) wrap_up();
  endtask

  task env(input int hi, input int lo, input int en, input int cb);
    detectors[hi] <= 1'b1;
    @(posedge mclk);
    detectors[hi] <= 1'b0;
    expect_rst(5, 1'b1, cb);
    repeat (8) @(posedge mclk);
    check({32'h0, system_reset}, 33'h1);
    detectors[lo] <= 1'b1;
    @(posedge mclk);
    detectors[lo] <= 1'b0;
    repeat (4) @(posedge mclk);
    check({32'h0, system_reset}, 33'h0);
    if (en >= 0) begin
      option_register[en] <= 1'b0;
      detectors[hi] <= 1'b1;
      @(posedge mclk);
      detectors[hi] <= 1'b0;
      expect_rst(5, 1'b0, -1);
      detectors[lo] <= 1'b1;
      @(posedge mclk);
      detectors[lo] <= 1'b0;
      option_register[en] <= 1'b1;
    end
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rnd = xs(rnd);
    apb(1'b1, wdog_pkg::USER_BYTE_OFS, {24'h0, rnd[7:0]}, WR);
    apb(1'b0, wdog_pkg::CLEAR_LOC_OFS, 0, {1'b0, 32'hFF, 24'h0, rnd[7:0]});
    apb(1'b0, 16'h0010, 0, {1'b1, 64'h0});
    apb(1'b0, wdog_pkg::STATUS_OFS, 0, {1'b0, 32'hF, 32'h0});
    apb(1'b1, wdog_pkg::CTRL_OFS, 1, WR);
    apb(1'b1, wdog_pkg::CTRL_OFS, 0, WR);
    apb(1'b0, wdog_pkg::STATUS_OFS, 0, {1'b0, 32'h5, 32'h4});
    // Let the post-reset hold run out so every tick below is counted.
    repeat (4100) @(posedge mclk);
    wdog_tick <= 1'b1;
    repeat (32800) @(posedge mclk);
    wdog_tick <= 1'b0;
    apb(1'b0, wdog_pkg::STATUS_OFS, 0, {1'b0, 32'h1, 32'h1});
    apb(1'b1, wdog_pkg::CLEAR_LOC_OFS, 0, WR);
    expect_rst(20, 1'b0, -1);
    apb(1'b0, wdog_pkg::STATUS_OFS, 0, {1'b0, 32'h1, 32'h0});
    apb(1'b1, wdog_pkg::CLEAR_LOC_OFS, 0, WR);
    expect_rst(20, 1'b1, 6);
    repeat (4) @(posedge mclk);
    apb(1'b0, wdog_pkg::STATUS_OFS, 0, {1'b0, 32'hC, 32'h8});
    for (int k = 0; k < 6; k++) begin
      fetch_addr <= fz[k][15:0];
      fetch_valid <= 1'b1;
      @(posedge mclk);
      fetch_valid <= 1'b0;
      expect_rst(5, fz[k][16], fz[k][16] ? 5 : -1);
    end
    stop_exec <= 1'b1;
    @(posedge mclk);
    stop_exec <= 1'b0;
    expect_rst(5, 1'b1, 4);
    wait_state <= 1'b1;
    env(6, 5, 2, 3);
    env(4, 3, 1, 2);
    env(2, 1, -1, 1);
    wait_state <= 1'b0;
    // A legal stop: watchdog and clock monitor sleep, nothing resets.
    option_register.stop_disable <= 1'b0;
    stop_exec <= 1'b1;
    @(posedge mclk);
    stop_exec <= 1'b0;
    wdog_tick <= 1'b1;
    run_clk <= 1'b0;
    expect_rst(20100, 1'b0, -1);
    check({32'h0, rc_oscillator_in_use}, 33'h0);
    stop_wake_irq <= 1'b1;
    @(posedge mclk);
    stop_wake_irq <= 1'b0;
    expect_rst(4000, 1'b0, -1);
    check({32'h0, rc_oscillator_in_use}, 33'h0);
    wdog_tick <= 1'b0;
    run_clk <= 1'b1;
    option_register.stop_disable <= 1'b1;
    repeat (100) @(posedge mclk);
    run_clk <= 1'b0;
    for (n = 0; n < 20100 && rc_oscillator_in_use !== 1'b1; n++)
      @(posedge mclk);
    check({32'h0, n >= 19990 && n <= 20010}, 33'h1);
    run_clk <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, wdog_pkg::STATUS_OFS, 0, {1'b0, 32'h2, 32'h2});
    repeat (2) @(posedge mclk);
    wrap_up();
  end
endmodule
